// file: src/timer_compare_rti_pkg.sv
// Purpose: shared constants for the timer compare and periodic tick unit
// Assumes: byte-wide register port, byte addresses as printed
// Notes: pin vectors are indexed 4..0 for port A pins 7..3
package timer_compare_rti_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int NUM_PINS = 5;
  localparam int NUM_CMP = 5;
  // register byte addresses
  localparam logic [7:0] ADDR_PIN_MASK = 8'h0C;
  localparam logic [7:0] ADDR_PIN_DATA = 8'h0D;
  localparam logic [7:0] ADDR_COUNT_HI = 8'h0E;
  localparam logic [7:0] ADDR_COUNT_LO = 8'h0F;
  localparam logic [7:0] ADDR_ACTION_CTRL = 8'h20;
  localparam logic [7:0] ADDR_IRQ_EN1 = 8'h22;
  localparam logic [7:0] ADDR_FLAGS1 = 8'h23;
  localparam logic [7:0] ADDR_IRQ_EN2 = 8'h24;
  localparam logic [7:0] ADDR_FLAGS2 = 8'h25;
  localparam logic [7:0] ADDR_ACC_CTRL = 8'h26;
  // field layouts and reset values
  localparam logic [7:0] PIN_FIELD_MASK = 8'hF8;
  localparam logic [7:0] FLAGS2_MASK = 8'hF0;
  localparam logic [7:0] ACC_CTRL_MASK = 8'h07;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam int PIN_LSB = 3;
  localparam int SHARED_BIT = 3;
  localparam int WRAP_BIT = 7;
  localparam int TICK_BIT = 6;
  localparam int ACC_OVF_BIT = 5;
  localparam int ACC_EDGE_BIT = 4;
  localparam int SELECT_BIT = 2;
  // compare action encodings, mode bit then level bit
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_LOW = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;
  // prescaler terminal counts for divide by 1, 4, 8, 16
  localparam logic [3:0] PRE_LAST_1 = 4'h0;
  localparam logic [3:0] PRE_LAST_4 = 4'h3;
  localparam logic [3:0] PRE_LAST_8 = 4'h7;
  localparam logic [3:0] PRE_LAST_16 = 4'hF;
  // prescaler write window after reset, in bus cycles
  localparam logic [6:0] PRESCALE_WINDOW = 7'h40;
  localparam int TICK_DIV_W = 16;
endpackage

// file: src/timer_compare_rti_unit.sv
// Purpose: free-running counter, compare pin actions, flags and periodic tick
// Assumes: ref_clk_i is the bus clock; compare values and capture edges come
//   from same-clock logic; reads return data one cycle after the strobe
// Notes: compare registers, capture edge logic and accumulator live outside
//
// Summary of operation
// - mask bits 7..3 let compare one drive the matching port pin.
// - compare one match copies data bits onto masked port pins.
// - mask and data bits 2..0 read zero; both reset to zero.
// - 16-bit counter at prescaled rate, reset to zero, read only.
// - high byte read latches low byte for a low read in the next cycle.
// - mode/level pair: 00 off, 01 toggle, 10 low, 11 high.
// - action byte holds pairs for channels two to five, reset zero.
// - fifth compare acts only while capture/compare select is clear.
// - enable bit beside set flag requests an interrupt.
// - shared bit 3 serves fourth capture or fifth compare by select.
// - writing one clears exactly those flags.
// - compare flag set whenever counter equals compare value.
// - capture flag set on each detected active edge.
// - wrap flag set when counter rolls from all ones to zero.
// - wrap enable requests an interrupt while wrap flag is set.
// - prescaler divides by 1, 4, 8 or 16.
// - prescaler written once, only within 64 cycles of reset.
// - second flag register low nibble reads zero.
// - periodic period is bus clock over 2^13 to 2^16.
// - periodic divider runs freely, never restarted by flag clears.
// - every periodic timeout sets tick flag, may request interrupt.
// - first periodic flag comes one full period after reset.
// - compares checked once per counter value; match sets flag and acts.
// - pin action happens on every match regardless of flag.
// - high byte compare write blocks that compare for one cycle.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module timer_compare_rti_unit
  import timer_compare_rti_pkg::*;
#(
  parameter int TICK_BASE_LOG2 = 13
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic [CNT_W-1:0] compare1_value_i,
  input wire logic [CNT_W-1:0] compare2_value_i,
  input wire logic [CNT_W-1:0] compare3_value_i,
  input wire logic [CNT_W-1:0] compare4_value_i,
  input wire logic [CNT_W-1:0] compare5_value_i,
  input wire logic [NUM_CMP-1:0] compare_hi_write_i,
  input wire logic [3:0] capture_edge_i,
  input wire logic acc_overflow_event_i,
  input wire logic acc_edge_event_i,
  output logic [NUM_PINS-1:0] port_a_upper_pins_o,
  output logic [NUM_PINS-1:0] port_a_upper_drive_o,
  output logic timer_irq_o
);

  logic [7:0] pin_mask_reg;
  logic [7:0] pin_data_reg;
  logic [7:0] action_ctrl_reg;
  logic [7:0] irq_en1_reg;
  logic [7:0] flags1_reg;
  logic [7:0] irq_en2_reg;
  logic [7:0] flags2_reg;
  logic [7:0] acc_ctrl_reg;
  logic [CNT_W-1:0] count_reg;
  logic [3:0] pre_cnt_reg;
  logic count_adv_reg;
  logic [7:0] lo_buffer_reg;
  logic lo_hold_reg;
  logic [6:0] boot_cnt_reg;
  logic pre_locked_reg;
  logic [TICK_DIV_W-1:0] tick_div_reg;
  logic [NUM_PINS-1:0] pin_level_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [CNT_W-1:0] cmp_value [NUM_CMP];
  logic [NUM_CMP-1:0] match;
  logic cnt_tick;
  logic periodic_tick;
  logic capture_compare_select;
  logic [7:0] flags1_set;
  logic [7:0] flags2_set;
  logic wr_flags1;
  logic wr_flags2;

  // terminal count of the prescaler for a select value
  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    case (sel)
      2'h0: pre_last = PRE_LAST_1;
      2'h1: pre_last = PRE_LAST_4;
      2'h2: pre_last = PRE_LAST_8;
      default: pre_last = PRE_LAST_16;
    endcase
  endfunction

  // pin action of one mode/level pair on a match
  function automatic logic pin_action(input logic [1:0] act, input logic cur);
    case (act)
      ACT_TOGGLE: pin_action = ~cur;
      ACT_LOW: pin_action = 1'b0;
      ACT_HIGH: pin_action = 1'b1;
      default: pin_action = cur;
    endcase
  endfunction

  assign capture_compare_select = acc_ctrl_reg[SELECT_BIT];
  assign wr_flags1 = reg_wr_i && (reg_addr_i == ADDR_FLAGS1);
  assign wr_flags2 = reg_wr_i && (reg_addr_i == ADDR_FLAGS2);

  // prescaler and free-running counter
  assign cnt_tick = (pre_cnt_reg == pre_last(irq_en2_reg[1:0]));
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pre_cnt_reg <= 4'h0;
      count_reg <= COUNT_RESET;
      count_adv_reg <= 1'b0;
    end else begin
      pre_cnt_reg <= cnt_tick ? 4'h0 : pre_cnt_reg + 4'h1;
      if (cnt_tick) begin
        count_reg <= count_reg + 16'h0001;
      end
      count_adv_reg <= cnt_tick;
    end
  end

  // one match per counter value, gated by a high-byte compare write
  assign cmp_value[0] = compare1_value_i;
  assign cmp_value[1] = compare2_value_i;
  assign cmp_value[2] = compare3_value_i;
  assign cmp_value[3] = compare4_value_i;
  assign cmp_value[4] = compare5_value_i;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      assign match[gi] = count_adv_reg && (count_reg == cmp_value[gi])
        && !compare_hi_write_i[gi];
    end
  endgenerate

  // periodic divider never restarts except at reset, so periods do not drift
  assign periodic_tick = &(tick_div_reg | ~((TICK_DIV_W'(1) <<
    (TICK_BASE_LOG2 + int'(acc_ctrl_reg[1:0]))) - TICK_DIV_W'(1)));
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tick_div_reg <= '0;
    end else begin
      tick_div_reg <= tick_div_reg + TICK_DIV_W'(1);
    end
  end

  // flag set sources; shared bit picks capture four or compare five
  always_comb begin
    flags1_set = {match[0], match[1], match[2], match[3], 1'b0, capture_edge_i[0],
      capture_edge_i[1], capture_edge_i[2]};
    flags1_set[SHARED_BIT] = capture_compare_select ? capture_edge_i[3]
      : match[4];
    flags2_set = 8'h00;
    flags2_set[WRAP_BIT] = cnt_tick && (count_reg == COUNT_ALL_ONES);
    flags2_set[TICK_BIT] = periodic_tick;
    flags2_set[ACC_OVF_BIT] = acc_overflow_event_i;
    flags2_set[ACC_EDGE_BIT] = acc_edge_event_i;
  end

  // sticky flags: write one clears, a same-cycle event wins over the clear
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flags1_reg <= REG_RESET;
      flags2_reg <= REG_RESET;
    end else begin
      flags1_reg <= flags1_set | (flags1_reg & ~(wr_flags1 ? reg_wdata_i
        : 8'h00));
      flags2_reg <= (flags2_set | (flags2_reg & ~(wr_flags2 ? reg_wdata_i
        : 8'h00))) & FLAGS2_MASK;
    end
  end

  // write-once prescaler window
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      boot_cnt_reg <= 7'h00;
      pre_locked_reg <= 1'b0;
    end else begin
      if (boot_cnt_reg != PRESCALE_WINDOW) begin
        boot_cnt_reg <= boot_cnt_reg + 7'h01;
      end
      if ((boot_cnt_reg == PRESCALE_WINDOW - 7'h01) ||
          (reg_wr_i && reg_addr_i == ADDR_IRQ_EN2)) begin
        pre_locked_reg <= 1'b1;
      end
    end
  end

  // software-written control registers
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pin_mask_reg <= REG_RESET;
      pin_data_reg <= REG_RESET;
      action_ctrl_reg <= REG_RESET;
      irq_en1_reg <= REG_RESET;
      irq_en2_reg <= REG_RESET;
      acc_ctrl_reg <= REG_RESET;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_PIN_MASK) begin
        pin_mask_reg <= reg_wdata_i & PIN_FIELD_MASK;
      end else if (reg_addr_i == ADDR_PIN_DATA) begin
        pin_data_reg <= reg_wdata_i & PIN_FIELD_MASK;
      end else if (reg_addr_i == ADDR_ACTION_CTRL) begin
        action_ctrl_reg <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_IRQ_EN1) begin
        irq_en1_reg <= reg_wdata_i;
      end else if (reg_addr_i == ADDR_IRQ_EN2) begin
        irq_en2_reg[7:4] <= reg_wdata_i[7:4];
        if (!pre_locked_reg) begin
          irq_en2_reg[1:0] <= reg_wdata_i[1:0];
        end
      end else if (reg_addr_i == ADDR_ACC_CTRL) begin
        acc_ctrl_reg <= reg_wdata_i & ACC_CTRL_MASK;
      end
    end
  end

  // pin levels: per-channel pairs first, compare one overrides its pins
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pin_level_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (i == 4) begin
          pin_level_reg[i] <= (match[0] && pin_mask_reg[i+PIN_LSB])
            ? pin_data_reg[i+PIN_LSB] : pin_level_reg[i];
        end else if (match[0] && pin_mask_reg[i+PIN_LSB]) begin
          pin_level_reg[i] <= pin_data_reg[i+PIN_LSB];
        end else if (match[4-i] && (i != 0 || !capture_compare_select)) begin
          pin_level_reg[i] <= pin_action(action_ctrl_reg[2*i+1 -: 2],
            pin_level_reg[i]);
        end
      end
    end
  end

  // a pin is owned while compare one masks it or its pair is connected
  always_comb begin
    port_a_upper_drive_o = pin_mask_reg[7:PIN_LSB];
    for (int i = 0; i < NUM_PINS - 1; i++) begin
      if (action_ctrl_reg[2*i+1 -: 2] != ACT_NONE &&
          (i != 0 || !capture_compare_select)) begin
        port_a_upper_drive_o[i] = 1'b1;
      end
    end
  end
  assign port_a_upper_pins_o = pin_level_reg;

  assign timer_irq_o = (|(irq_en1_reg & flags1_reg))
    || (|(irq_en2_reg & flags2_reg & FLAGS2_MASK));

  // coherent count read: the low byte is frozen for one cycle after the high read
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      lo_buffer_reg <= 8'h00;
      lo_hold_reg <= 1'b0;
    end else begin
      lo_hold_reg <= reg_rd_i && (reg_addr_i == ADDR_COUNT_HI);
      if (reg_rd_i && reg_addr_i == ADDR_COUNT_HI) begin
        lo_buffer_reg <= count_reg[7:0];
      end
    end
  end

  // read mux; unmapped addresses return zero
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == ADDR_PIN_MASK) begin
        rdata_reg <= pin_mask_reg;
      end else if (reg_addr_i == ADDR_PIN_DATA) begin
        rdata_reg <= pin_data_reg;
      end else if (reg_addr_i == ADDR_COUNT_HI) begin
        rdata_reg <= count_reg[15:8];
      end else if (reg_addr_i == ADDR_COUNT_LO) begin
        rdata_reg <= lo_hold_reg ? lo_buffer_reg : count_reg[7:0];
      end else if (reg_addr_i == ADDR_ACTION_CTRL) begin
        rdata_reg <= action_ctrl_reg;
      end else if (reg_addr_i == ADDR_IRQ_EN1) begin
        rdata_reg <= irq_en1_reg;
      end else if (reg_addr_i == ADDR_FLAGS1) begin
        rdata_reg <= flags1_reg;
      end else if (reg_addr_i == ADDR_IRQ_EN2) begin
        rdata_reg <= irq_en2_reg;
      end else if (reg_addr_i == ADDR_FLAGS2) begin
        rdata_reg <= flags2_reg;
      end else if (reg_addr_i == ADDR_ACC_CTRL) begin
        rdata_reg <= acc_ctrl_reg;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end
  assign reg_rdata_o = rdata_reg;

  // checks
  property p_wrap_flag;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (cnt_tick && count_reg == COUNT_ALL_ONES)
      |=> (flags2_reg[WRAP_BIT] && count_reg == COUNT_RESET);
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap flag missed");
  property p_w1c;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_flags1 && reg_wdata_i[7] && !flags1_set[7]) |=> !flags1_reg[7];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");
  property p_zero_keeps;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_flags1 && !reg_wdata_i[7] && flags1_reg[7]) |=> flags1_reg[7];
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost on zero write");
  property p_mask_low_zero;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == ADDR_PIN_MASK) |=> (reg_rdata_o[2:0] == 3'h0);
  endproperty
  a_mask_low_zero: assert property (p_mask_low_zero) else $error("mask low bits set");

  property p_coherent;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (reg_rd_i && reg_addr_i == ADDR_COUNT_HI) ##1 (reg_rd_i && reg_addr_i == ADDR_COUNT_LO)
      |=> (reg_rdata_o == $past(count_reg[7:0], 2));
  endproperty
  a_coherent: assert property (p_coherent) else $error("count read not coherent");
  property p_pre_lock;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    pre_locked_reg |=> $stable(irq_en2_reg[1:0]);
  endproperty
  a_pre_lock: assert property (p_pre_lock) else $error("prescaler changed after lock");
  property p_irq;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (|(irq_en1_reg & flags1_set)) && !(reg_wr_i && reg_addr_i == ADDR_IRQ_EN1)
      |=> timer_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("enabled flag gives no request");
  property p_bcast_pin;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (match[0] && pin_mask_reg[7]) |=> (port_a_upper_pins_o[4] == $past(pin_data_reg[7]));
  endproperty
  a_bcast_pin: assert property (p_bcast_pin) else $error("broadcast data not on pin");

  property p_toggle;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (match[1] && action_ctrl_reg[7:6] == ACT_TOGGLE && !(match[0] && pin_mask_reg[6]))
      |=> (port_a_upper_pins_o[3] != $past(port_a_upper_pins_o[3]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle action missed");
  property p_tick_flag;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    periodic_tick |=> flags2_reg[TICK_BIT];
  endproperty
  a_tick_flag: assert property (p_tick_flag) else $error("periodic flag missed");

  c_match_irq: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    match[0] ##1 timer_irq_o);
  c_wrap: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) flags2_set[WRAP_BIT]);
  c_tick: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) periodic_tick);
  c_set_clear: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_flags1 && reg_wdata_i[7] && flags1_set[7]);

endmodule

// file: verification/cpu_bus_model.sv
// Purpose: cpu side of the register port, one bus cycle per call
// Assumes: calls start just after a rising edge; every signal is set in one step
// Notes: address and data move to fresh patterns while idle so stale values never look valid
`timescale 1ns/1ps
module cpu_bus_model (
  input wire logic ref_clk_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  // all outputs quiet before the first edge
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // request held whole cycle up to the taking edge; the slave never stalls
  task automatic cycle(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    reg_wr_o <= w;
    reg_rd_o <= r;
    reg_addr_o <= (w | r) ? a : ~reg_addr_o;
    reg_wdata_o <= w ? d : ~reg_wdata_o;
    @(posedge ref_clk_i);
  endtask
endmodule

// file: verification/tb_top.sv
// Purpose: self-checking bench for the timer compare and periodic tick unit
// Assumes: read data are sampled at the edge after the read is taken
// Notes: short tick base keeps the run small; wrap needs a second reset at divide by 1
`timescale 1ns/1ps
module tb_top;
  import timer_compare_rti_pkg::*;
  localparam int TICK_LOG2 = 6;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, irq;
  logic [15:0] cv [5] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  logic [3:0] cap = 4'h0;
  logic acc_ovf = 1'b0;
  logic acc_edge = 1'b0;
  logic [4:0] hiw = 5'h00;
  logic [4:0] pins, drive;
  logic [15:0] rd_q [$];
  logic rd_seen = 1'b0;
  logic [15:0] seen16 = 16'h0000;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int rel = 0;

  timer_compare_rti_unit #(.TICK_BASE_LOG2(TICK_LOG2)) timer_compare_rti_unit_i (
    .ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .compare1_value_i(cv[0]),
    .compare2_value_i(cv[1]), .compare3_value_i(cv[2]), .compare4_value_i(cv[3]),
    .compare5_value_i(cv[4]), .compare_hi_write_i(hiw), .capture_edge_i(cap),
    .acc_overflow_event_i(acc_ovf), .acc_edge_event_i(acc_edge),
    .port_a_upper_pins_o(pins), .port_a_upper_drive_o(drive), .timer_irq_o(irq));

  cpu_bus_model cpu_bus_model_i (.ref_clk_i(clk), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_wr_o(wr), .reg_rd_o(rd));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [7:0] m, input logic [7:0] e, input logic [7:0] s);
    // a zero mask only collects bytes for a later check, so it is not counted
    if (m != 8'h00) begin
      checks++;
    end
    if ((s & m) !== (e & m)) begin
      errors++;
      $display("ERROR rdata expected %h seen %h mask %h", e, s, m);
    end
  endtask

  task automatic cmp_out(input string what, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask

  // read data appear in the cycle after the strobe, so compare exactly there
  always @(posedge clk) begin
    logic [15:0] n;
    if (rd_seen) begin
      n = rd_q.pop_front();
      cmp_rd(n[15:8], n[7:0], rdata);
      seen16 <= {seen16[7:0], rdata};
    end
    rd_seen <= rd;
  end

  // hang guard sized for the wrap wait plus the first phase
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic idle(input int n);
    repeat (n) cpu_bus_model_i.cycle(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    cpu_bus_model_i.cycle(1'b1, 1'b0, a, d);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    rd_q.push_back({m, e});
    cpu_bus_model_i.cycle(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    rel = cyc;
  endtask
  // high then low back to back; value is the count at the high read
  task automatic get_count(output logic [15:0] v);
    rreg(ADDR_COUNT_HI, 8'h00, 8'h00);
    rreg(ADDR_COUNT_LO, 8'h00, 8'h00);
    idle(2);
    v = seen16;
  endtask
  // place selected compares a few counts ahead and let them fire
  task automatic arm(input logic [4:0] sel);
    logic [15:0] v;
    get_count(v);
    for (int k = 0; k < 5; k++) begin
      if (sel[k]) begin
        cv[k] <= v + 16'h0003;
      end
    end
    idle(20);
  endtask
  task automatic wait_irq(output int t);
    // a clearing write just before lands on this edge; look one cycle later
    idle(1);
    for (int k = 0; k < 70000 && irq !== 1'b1; k++) begin
      idle(1);
    end
    t = cyc;
  endtask
  // late clear must not stretch the period
  task automatic tick_gap(input int dly, output int d);
    int t1, t2;
    wreg(ADDR_FLAGS2, 8'h40);
    wait_irq(t1);
    idle(dly);
    wreg(ADDR_FLAGS2, 8'h40);
    wait_irq(t2);
    d = t2 - t1;
  endtask

  initial begin
    logic [15:0] v1, v2;
    logic [7:0] m, d, w, e;
    logic [1:0] acts [5];
    logic [3:0] pexp [5];
    logic [7:0] regs [8];
    int t;
    acts = '{ACT_HIGH, ACT_TOGGLE, ACT_TOGGLE, ACT_LOW, ACT_NONE};
    pexp = '{4'hF, 4'h0, 4'hF, 4'h0, 4'h0};
    regs = '{8'h0C, 8'h0D, 8'h20, 8'h22, 8'h23, 8'h24, 8'h25, 8'h30};
    void'($urandom(32'hB072DA62));
    do_reset();
    wreg(ADDR_IRQ_EN2, 8'h41);
    wait_irq(t);
    cmp_out("first_tick", 16'h0001, 16'((t - rel) inside {[62:66]}));
    tick_gap(20, t);
    cmp_out("tick_gap", 16'(1 << TICK_LOG2), 16'(t));
    wreg(ADDR_IRQ_EN2, 8'h03);
    get_count(v1);
    wreg(ADDR_COUNT_HI, 8'hFF);
    wreg(ADDR_COUNT_LO, 8'hFF);
    idle(34);
    get_count(v2);
    cmp_out("count_rate", v1 + 16'h000A, v2);
    for (int i = 0; i < 5; i++) begin
      wreg(ADDR_ACTION_CTRL, {4{acts[i]}});
      arm(5'h1E);
      cmp_out("drive", (i < 4) ? 16'h000F : 16'h0000, 16'(drive[3:0]));
      if (i < 4) begin
        cmp_out("pins", 16'(pexp[i]), 16'(pins[3:0]));
      end
    end
    rreg(ADDR_FLAGS1, 8'hFF, 8'h78);
    wreg(ADDR_FLAGS1, 8'hFF);
    wreg(ADDR_ACC_CTRL, 8'h04);
    wreg(ADDR_ACTION_CTRL, 8'hFF);
    arm(5'h1E);
    cmp_out("drive_sel", 16'h000E, 16'(drive[3:0]));
    cmp_out("pins_sel", 16'h000E, 16'(pins[3:0]));
    rreg(ADDR_FLAGS1, 8'hFF, 8'h70);
    cap <= 4'hF;
    idle(1);
    cap <= 4'h0;
    rreg(ADDR_FLAGS1, 8'hFF, 8'h7F);
    acc_ovf <= 1'b1;
    acc_edge <= 1'b1;
    idle(1);
    acc_ovf <= 1'b0;
    acc_edge <= 1'b0;
    rreg(ADDR_FLAGS2, 8'h3F, 8'h30);
    wreg(ADDR_FLAGS2, 8'h30);
    rreg(ADDR_FLAGS2, 8'h3F, 8'h00);
    m = 8'($urandom);
    d = 8'($urandom);
    wreg(ADDR_PIN_MASK, m);
    wreg(ADDR_PIN_DATA, d);
    rreg(ADDR_PIN_MASK, 8'hFF, m & 8'hF8);
    rreg(ADDR_PIN_DATA, 8'hFF, d & 8'hF8);
    arm(5'h01);
    cmp_out("drive_c1", 16'(m[7:3] | 5'h0E), 16'(drive));
    cmp_out("pins_c1", 16'(d[7:3] & m[7:3]), 16'(pins & m[7:3]));
    rreg(ADDR_FLAGS1, 8'hFF, 8'hFF);
    w = 8'($urandom);
    wreg(ADDR_FLAGS1, w);
    rreg(ADDR_FLAGS1, 8'hFF, ~w);
    e = 8'($urandom);
    wreg(ADDR_IRQ_EN1, e);
    rreg(ADDR_IRQ_EN1, 8'hFF, e);
    idle(1);
    cmp_out("irq1", 16'(|(e & ~w)), 16'(irq));
    // a high-byte write held over the whole window keeps channel two from matching
    wreg(ADDR_FLAGS1, 8'hFF);
    wreg(ADDR_IRQ_EN1, 8'h60);
    hiw <= 5'h02;
    arm(5'h06);
    hiw <= 5'h00;
    rreg(ADDR_FLAGS1, 8'hFF, 8'h20);
    cmp_out("irq_c3", 16'h0001, 16'(irq));
    wreg(ADDR_IRQ_EN1, 8'h00);
    wreg(ADDR_IRQ_EN2, 8'h40);
    for (int r = 1; r < 4; r++) begin
      wreg(ADDR_ACC_CTRL, 8'(r));
      tick_gap(0, t);
      cmp_out("tick_rate", 16'(1 << (TICK_LOG2 + r)), 16'(t));
    end
    do_reset();
    foreach (regs[i]) begin
      rreg(regs[i], 8'hFF, 8'h00);
    end
    wreg(ADDR_IRQ_EN2, 8'h80);
    wait_irq(t);
    cmp_out("wrap_time", 16'h0001, 16'((t - rel) inside {[65533:65540]}));
    rreg(ADDR_FLAGS2, 8'h8F, 8'h80);
    wreg(ADDR_FLAGS2, 8'h00);
    rreg(ADDR_FLAGS2, 8'h80, 8'h80);
    wreg(ADDR_IRQ_EN2, 8'h00);
    idle(1);
    cmp_out("irq_off", 16'h0000, 16'(irq));
    tally_and_finish();
  end
endmodule
